//--- logic/adc_ctrl_pkg.sv
/*
  Types of the converter track and burst controller.
  Assumes the constants header is compiled alongside.
*/
package adc_ctrl_pkg;

  // Controller states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PWRUP = 3'b001,
    ST_TRACK = 3'b010,
    ST_CONV = 3'b011,
    ST_ACC = 3'b100
  } state_t;

  // Configuration bits written by software.
  typedef struct packed {
    logic converter_enable_bit;
    logic burst_enable_bit;
    logic low_power_track_sel;
    logic [2:0] start_source_select;
    logic eight_bit_mode_bit;
    logic twelve_bit_mode_bit;
    logic gain_select_bit;
    logic [2:0] repeat_count;
    logic [4:0] power_up_time_field;
    logic [5:0] burst_track_time_field;
    logic [4:0] sar_clock_div;
    logic standby;
  } cfg_t;

  // Controls toward the analog converter.
  typedef struct packed {
    logic track;
    logic power;
    logic [9:0] dac_code;
    logic [1:0] ref_level;
    logic [1:0] dem_rotation;
    logic gain_half;
  } analog_ctrl_t;

endpackage

//--- logic/adc_ctrl_regs.svh
/*
  Constants of the converter track and burst controller: start source codes,
  reset values and timing counts.
  Assumes inclusion by bare name from the design files.
*/
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

// Start source select codes.
`define SRC_SOFTWARE 3'h0
`define SRC_TIMER0 3'h1
`define SRC_TIMER2 3'h2
`define SRC_EXT_PIN 3'h4

// System clock period and nominal burst clock period in picoseconds.
`define CLK_PERIOD_PS 20000
`define BURST_PERIOD_PS 50000
// Burst tick spacing in system clocks, rounded down.
`define BURST_TICK_CYC (`BURST_PERIOD_PS / `CLK_PERIOD_PS)

// Extra SAR clocks of tracking in low-power tracking mode.
`define LP_TRACK_TICKS 7'h03

// Last bit index of a conversion in 10-bit and 8-bit mode.
`define LAST_BIT_10 4'h0
`define LAST_BIT_8 4'h2
`define FIRST_BIT 4'h9

// Largest sum of four 10-bit results.
`define TWELVE_MAX 16'h0FFC

// Reset values.
`define ACC_RESET 16'h0000
`define FLAG_RESET 1'b0

`endif

//--- logic/adc_track_burst_ctrl.sv
/*
  Track, burst, power and resolution control of a SAR converter.
  Assumes software drives the configuration and clears the flags, and the
  analog converter returns an asynchronous comparator level.
*/
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"
module adc_track_burst_ctrl
  import adc_ctrl_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Configuration and software strobes.
  input wire cfg_t cfg_i,
  input wire logic busy_start_bit_i,
  input wire logic done_clear_i,
  input wire logic window_clear_i,
  input wire logic [15:0] window_low_i,
  input wire logic [15:0] window_high_i,
  // Start sources.
  input wire logic timer0_ovf_i,
  input wire logic timer2_ovf_i,
  input wire logic ext_convert_start_pin_i,
  // Comparator level from the analog converter.
  input wire logic comp_i,
  // Analog controls.
  output analog_ctrl_t analog_o,
  // Status and result.
  output logic busy_o,
  output logic conversion_done_flag_o,
  output logic window_flag_o,
  output logic [7:0] result_high_byte_o,
  output logic [7:0] result_low_byte_o
);

  state_t state;
  state_t next_state;
  logic ext_sync1, ext_sync2, ext_prev;
  logic comp_sync1, comp_sync2;
  logic [1:0] burst_cnt;
  logic [6:0] phase_cnt;
  logic [6:0] conv_cnt;
  logic [3:0] bit_idx;
  logic [3:0] conv_ticks;
  logic [9:0] sar_reg;
  logic [15:0] acc;
  logic [15:0] result;
  logic sar_tick;
  analog_ctrl_t next_analog;

  // Pin and comparator levels pass two flip-flops first.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
      ext_prev <= 1'b0;
      comp_sync1 <= 1'b0;
      comp_sync2 <= 1'b0;
    end else begin
      ext_sync1 <= ext_convert_start_pin_i;
      ext_sync2 <= ext_sync1;
      ext_prev <= ext_sync2;
      comp_sync1 <= comp_i;
      comp_sync2 <= comp_sync1;
    end
  end

  // Burst clock ticks every 2 system clocks (25 MHz); it wakes in phase with each start.
  wire logic burst_tick = (burst_cnt == 2'(`BURST_TICK_CYC - 1));
  wire logic src_tick = cfg_i.burst_enable_bit ? burst_tick : 1'b1;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      burst_cnt <= 2'h0;
    end else begin
      burst_cnt <= (burst_tick || start_go) ? 2'h0 : burst_cnt + 2'h1;
    end
  end

  // Start source decode and edge of the external pin.
  wire logic ext_rise = ext_sync2 && !ext_prev;
  wire logic [2:0] src = cfg_i.start_source_select;
  wire logic src_is_ext = (src == `SRC_EXT_PIN);
  wire logic start_sel =
    (src == `SRC_SOFTWARE) ? busy_start_bit_i :
    (src == `SRC_TIMER0) ? timer0_ovf_i :
    (src == `SRC_TIMER2) ? timer2_ovf_i :
    src_is_ext ? ext_rise : 1'b0;
  wire logic can_start =
    cfg_i.converter_enable_bit || cfg_i.burst_enable_bit;
  // A start while a conversion runs is dropped.
  wire logic start_go = start_sel && can_start && (state == ST_IDLE);

  // SAR tick from the system clock or the burst clock.
  sar_tick_gen u_tick (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .src_tick_i(src_tick),
    .div_i(cfg_i.sar_clock_div),
    .restart_i(start_go),
    .tick_o(sar_tick)
  );

  // Tracking length in SAR ticks before each conversion.
  wire logic lp_pin_mode =
    cfg_i.low_power_track_sel && src_is_ext && !cfg_i.burst_enable_bit;
  wire logic [6:0] burst_track =
    cfg_i.burst_enable_bit ? {1'b0, cfg_i.burst_track_time_field}
                           : 7'h00;
  wire logic [6:0] lp_track =
    (cfg_i.low_power_track_sel && !lp_pin_mode) ? `LP_TRACK_TICKS
                                                : 7'h00;
  wire logic [6:0] track_len = burst_track + lp_track;
  wire state_t first_phase = (track_len != 7'h00) ? ST_TRACK : ST_CONV;

  // Power state: burst idles powered only with the enable bit or within a series.
  wire logic powered = cfg_i.converter_enable_bit ||
    (cfg_i.burst_enable_bit && conv_cnt != 7'h00);
  wire logic [6:0] phase_target = (state == ST_PWRUP) ?
    {2'b00, cfg_i.power_up_time_field} + 7'h01 : track_len;
  wire logic phase_last = sar_tick && (phase_cnt + 7'h01 == phase_target);

  // Repeat count totals and series bookkeeping.
  wire logic [6:0] rpt_total =
    (cfg_i.repeat_count == 3'h0) ? 7'h01 :
    (cfg_i.repeat_count == 3'h1) ? 7'h04 :
    (cfg_i.repeat_count == 3'h2) ? 7'h08 :
    (cfg_i.repeat_count == 3'h3) ? 7'h10 :
    (cfg_i.repeat_count == 3'h4) ? 7'h20 : 7'h40;
  wire logic last_conv = (conv_cnt + 7'h01 >= rpt_total);
  wire logic series_end = (state == ST_ACC) && last_conv;
  wire logic burst_more = cfg_i.burst_enable_bit && !src_is_ext;

  // Bit decisions: 8-bit mode stops two bits early.
  wire logic [3:0] last_bit_idx =
    cfg_i.eight_bit_mode_bit ? `LAST_BIT_8 : `LAST_BIT_10;
  wire logic last_bit = (bit_idx == last_bit_idx);
  wire logic [9:0] trial_mask = 10'h001 << bit_idx;
  wire logic [9:0] dac_trial = sar_reg | trial_mask;

  // Accumulator restarts with the first conversion of a series.
  wire logic [15:0] acc_base =
    (conv_cnt == 7'h00) ? `ACC_RESET : acc;
  wire logic [15:0] acc_next =
    acc_base + {6'h00, sar_reg};
  wire logic in_window =
    (acc_next >= window_low_i) && (acc_next <= window_high_i);

  // Next state of the sequencer.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_go) begin
          next_state = powered ? first_phase : ST_PWRUP;
        end
      end
      ST_PWRUP: begin
        if (phase_last) begin
          next_state = first_phase;
        end
      end
      ST_TRACK: begin
        if (phase_last) begin
          next_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (sar_tick && last_bit) begin
          next_state = ST_ACC;
        end
      end
      ST_ACC: begin
        // A burst runs on; a pin-started burst waits per edge.
        if (!last_conv && burst_more) begin
          next_state = first_phase;
        end else begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  wire logic state_change = (next_state != state);
  wire logic enter_conv = (next_state == ST_CONV) && state_change;

  // State and phase counter.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      phase_cnt <= 7'h00;
    end else begin
      state <= next_state;
      phase_cnt <= state_change ? 7'h00 :
                   sar_tick ? phase_cnt + 7'h01 : phase_cnt;
    end
  end

  // Successive approximation: keep each trial bit the comparator passes.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sar_reg <= 10'h000;
      bit_idx <= `FIRST_BIT;
      conv_ticks <= 4'h0;
    end else if (enter_conv) begin
      sar_reg <= 10'h000;
      bit_idx <= `FIRST_BIT;
      conv_ticks <= 4'h0;
    end else if (state == ST_CONV && sar_tick) begin
      sar_reg <= comp_sync2 ? dac_trial : sar_reg;
      bit_idx <= bit_idx - 4'h1;
      conv_ticks <= conv_ticks + 4'h1;
    end
  end

  // Accumulation, series count and result update.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc <= `ACC_RESET;
      conv_cnt <= 7'h00;
      result <= `ACC_RESET;
    end else if (state == ST_ACC) begin
      acc <= acc_next;
      conv_cnt <= last_conv ? 7'h00 : conv_cnt + 7'h01;
      if (last_conv) begin
        result <= cfg_i.eight_bit_mode_bit ?
          {acc_next[15:8], 8'h00} : acc_next;
      end
    end
  end

  // Flags: a set in the clearing cycle wins.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conversion_done_flag_o <= `FLAG_RESET;
      window_flag_o <= `FLAG_RESET;
    end else begin
      if (series_end) begin
        conversion_done_flag_o <= 1'b1;
      end else if (done_clear_i) begin
        conversion_done_flag_o <= 1'b0;
      end
      if (series_end && in_window) begin
        window_flag_o <= 1'b1;
      end else if (window_clear_i) begin
        window_flag_o <= 1'b0;
      end
    end
  end

  // Analog controls, registered before they leave the block.
  wire logic idle_track = !cfg_i.burst_enable_bit &&
    cfg_i.converter_enable_bit &&
    (!cfg_i.low_power_track_sel || (lp_pin_mode && !ext_sync2));
  always_comb begin
    next_analog = '0;
    next_analog.track = !cfg_i.standby && ((state == ST_TRACK) ||
      (state == ST_IDLE && idle_track));
    next_analog.power = powered || (state != ST_IDLE);
    next_analog.dac_code = (state == ST_CONV) ? dac_trial : sar_reg;
    next_analog.ref_level = cfg_i.twelve_bit_mode_bit ?
      conv_cnt[1:0] : 2'h0;
    next_analog.dem_rotation = cfg_i.twelve_bit_mode_bit ?
      conv_cnt[1:0] : 2'h0;
    next_analog.gain_half = cfg_i.gain_select_bit;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      analog_o <= '0;
    end else begin
      analog_o <= next_analog;
    end
  end

  // Status outputs.
  assign busy_o = (state != ST_IDLE);
  assign result_high_byte_o = result[15:8];
  assign result_low_byte_o = result[7:0];

  // Checks on the sequencer.
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  a_idle_track_on: assert property (
    (state == ST_IDLE && !cfg_i.burst_enable_bit && !cfg_i.standby &&
     !cfg_i.low_power_track_sel && cfg_i.converter_enable_bit)
    |=> analog_o.track)
    else $error("Input not tracked while idle.");
  a_lp_track_len: assert property (
    (state == ST_TRACK && !cfg_i.burst_enable_bit)
    |-> (track_len == 7'h03 && phase_cnt < 7'h03))
    else $error("Low-power tracking not three ticks.");
  a_pin_edge_conv: assert property (
    (start_go && lp_pin_mode && cfg_i.converter_enable_bit)
    |=> state == ST_CONV)
    else $error("Pin edge did not start conversion.");
  a_burst_power_off: assert property (
    (state == ST_IDLE && cfg_i.burst_enable_bit &&
     !cfg_i.converter_enable_bit && conv_cnt == 7'h00) |=> !analog_o.power)
    else $error("Burst idle not powered down.");
  a_powerup_first: assert property (
    (start_go && !powered) |=> state == ST_PWRUP)
    else $error("Powered-down start skipped power-up.");
  a_conv_length: assert property (
    (state == ST_ACC) |->
    conv_ticks == (cfg_i.eight_bit_mode_bit ? 4'h8 : 4'hA))
    else $error("Wrong number of SAR ticks in conversion.");
  a_eight_lsb_zero: assert property (
    (state == ST_ACC && cfg_i.eight_bit_mode_bit) |-> sar_reg[1:0] == 2'h0)
    else $error("8-bit conversion has nonzero LSBs.");
  a_done_after_all: assert property (
    $rose(conversion_done_flag_o) |-> $past(series_end))
    else $error("Done flag raised before series end.");
  a_result_with_flag: assert property (
    $changed(result) |-> (conversion_done_flag_o && $past(series_end)))
    else $error("Result changed outside series end.");
  a_acc_restart: assert property (
    (state == ST_ACC && conv_cnt == 7'h00) |-> acc_next == {6'h00, sar_reg})
    else $error("Accumulator not cleared at series start.");
  a_twelve_max: assert property (
    (series_end && cfg_i.twelve_bit_mode_bit && rpt_total == 7'h04)
    |-> acc_next <= `TWELVE_MAX)
    else $error("12-bit result above 4092.");

  c_burst_series: cover property (
    series_end && cfg_i.burst_enable_bit && rpt_total == 7'h04);
  c_pin_lp_conv: cover property (start_go && lp_pin_mode);
  c_eight_done: cover property (series_end && cfg_i.eight_bit_mode_bit);
  c_powerup: cover property (state == ST_PWRUP ##1 state == ST_TRACK);

endmodule // adc_track_burst_ctrl

//--- logic/sar_tick_gen.sv
/*
  Divider that turns a source tick into the SAR clock tick.
  Assumes a source tick from logic on the same clock.
*/
`timescale 1ns/1ps
module sar_tick_gen (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Source tick, divide value and phase restart.
  input wire logic src_tick_i,
  input wire logic [4:0] div_i,
  input wire logic restart_i,
  // One-cycle SAR tick.
  output logic tick_o
);

  logic [4:0] count;
  wire logic wrap = src_tick_i && (count >= div_i);

  // The tick fires on every div_i+1-th source tick.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= 5'h00;
    end else if (restart_i || wrap) begin
      count <= 5'h00;
    end else if (src_tick_i) begin
      count <= count + 5'h01;
    end
  end

  assign tick_o = wrap && !restart_i;

endmodule // sar_tick_gen

//--- tb/adc_analog_model.sv
/*
  Behavioural analog converter that answers each DAC trial code.
  Assumes the controller samples the comparator through synchronisers.
*/
`timescale 1ns/1ps
module adc_analog_model
  import adc_ctrl_pkg::*;
(
  // Clock.
  input wire logic clock_i,
  // Controls from the converter logic and the input to convert.
  input wire analog_ctrl_t analog_i,
  input wire logic [9:0] vin_i,
  // Comparator level.
  output logic comp_o
);
  logic junk = 1'b0;

  // An unpowered comparator gives a level that changes every cycle.
  always @(posedge clock_i) begin
    junk <= ~junk;
  end

  // A powered comparator reports an input at or above the trial code.
  assign comp_o = analog_i.power ? (vin_i >= analog_i.dac_code) : junk;
endmodule // adc_analog_model

//--- tb/adc_track_burst_ctrl_tb_top.sv
/*
  Self-checking bench of the track and burst controller.
  Assumes the analog model under tb/ and the design files under logic/.
*/
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"
module adc_track_burst_ctrl_tb_top;
  import adc_ctrl_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  cfg_t cfg = '0;
  cfg_t c = '0;
  logic sw = 1'b0, dclr = 1'b0, wclr = 1'b0;
  logic t0 = 1'b0, t2 = 1'b0, pin = 1'b0;
  logic [15:0] wlo = 16'h0000, whi = 16'h0000, lo, hi;
  logic [9:0] vin = 10'h2A5, v;
  logic comp, busy, done, win, busy_d = 1'b0, trk, g0;
  logic arm = 1'b0;
  analog_ctrl_t ana;
  logic [7:0] rhi, rlo;
  logic [3:0] refs, rots;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  int len [4];

  always #10 clock_i = ~clock_i;

  adc_track_burst_ctrl DUT (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .cfg_i(cfg), .busy_start_bit_i(sw), .done_clear_i(dclr),
    .window_clear_i(wclr), .window_low_i(wlo), .window_high_i(whi),
    .timer0_ovf_i(t0), .timer2_ovf_i(t2), .ext_convert_start_pin_i(pin),
    .comp_i(comp), .analog_o(ana), .busy_o(busy),
    .conversion_done_flag_o(done), .window_flag_o(win),
    .result_high_byte_o(rhi), .result_low_byte_o(rlo));

  adc_analog_model u_model (.clock_i(clock_i), .analog_i(ana),
    .vin_i(vin), .comp_o(comp));

  // Watches tracking and reference use while busy; cuts a hang short.
  always @(posedge clock_i) begin
    busy_d <= busy;
    if (arm) begin
      trk <= 1'b0;
      refs <= 4'h0;
      rots <= 4'h0;
    end else if (busy && busy_d) begin
      trk <= trk | ana.track;
      refs[ana.ref_level] <= 1'b1;
      rots[ana.dem_rotation] <= 1'b1;
    end
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors++;
      stop_test();
    end
  end

  // Compares a seen value with the expected one.
  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hands the staged set-up to the design and lets it settle.
  task automatic apply();
    @(posedge clock_i);
    cfg <= c;
    wlo <= lo;
    whi <= hi;
    vin <= v;
    @(posedge clock_i);
    #1;
  endtask

  // Pulses both flag clears.
  task automatic clr();
    @(posedge clock_i);
    dclr <= 1'b1;
    wclr <= 1'b1;
    @(posedge clock_i);
    dclr <= 1'b0;
    wclr <= 1'b0;
    @(posedge clock_i);
    #1;
  endtask

  // Applies the set-up, pulses a start and measures busy in cycles.
  task automatic conv(input int src, output int n);
    apply();
    arm <= 1'b1;
    @(posedge clock_i);
    arm <= 1'b0;
    case (src)
      0: sw <= 1'b1;
      1: t0 <= 1'b1;
      2: t2 <= 1'b1;
      default: pin <= 1'b1;
    endcase
    @(posedge clock_i);
    {sw, t0, t2} <= 3'b000;
    #1;
    n = 0;
    for (int i = 0; i < 20 && busy !== 1'b1; i++) begin
      @(posedge clock_i);
      #1;
    end
    while (busy === 1'b1 && n < 3000) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    check("busy_end", busy, 1'b0);
    @(posedge clock_i);
    pin <= 1'b0;
    repeat (4) @(posedge clock_i);
    #1;
  endtask

  initial begin
    c.converter_enable_bit = 1'b1;
    c.sar_clock_div = 5'h03;
    v = 10'h2A5;
    lo = 16'h02A5;
    hi = 16'h02A5;
    repeat (11) @(posedge clock_i);
    #1;
    check("reset", {busy, done, win, rhi, rlo}, 24'h000000);
    check("reset_ana", ana, 24'h000000);
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    apply();
    check("idle_track", ana.track, 1'b1);
    conv(0, len[0]);
    check("conv_track", trk, 1'b0);
    check("result", {rhi, rlo}, 16'h02A5);
    check("done", done, 1'b1);
    check("window", win, 1'b1);
    clr();
    check("done_clr", {done, win}, 2'b00);
    c.low_power_track_sel = 1'b1;
    conv(0, len[1]);
    check("lp_len", len[1] - len[0], 12);
    check("lp_track", trk, 1'b1);
    c.low_power_track_sel = 1'b0;
    c.eight_bit_mode_bit = 1'b1;
    conv(0, len[2]);
    check("b8_len", len[0] - len[2], 8);
    check("b8_result", {rhi, rlo}, 16'h0200);
    c.eight_bit_mode_bit = 1'b0;
    c.repeat_count = 3'h1;
    hi = 16'h0A94;
    clr();
    conv(0, len[0]);
    check("rpt_early", {done, win}, 2'b00);
    repeat (3) conv(0, len[0]);
    check("rpt_done", {done, win}, 2'b11);
    check("rpt_sum", {rhi, rlo}, 16'h0A94);
    c.repeat_count = 3'h0;
    for (int s = 0; s < 3; s++) begin
      c.start_source_select = 3'(s);
      clr();
      conv(s, len[0]);
      check("src_start", done, 1'b1);
      clr();
      conv((s + 1) % 3, len[0]);
      check("src_other", done, 1'b0);
    end
    c.start_source_select = 3'h3;
    conv(0, len[0]);
    check("src_bad", {done, len[0][0]}, 2'b00);
    apply();
    g0 = ana.gain_half;
    c.gain_select_bit = 1'b1;
    apply();
    check("gain", {g0, ana.gain_half}, 2'b01);
    c.standby = 1'b1;
    apply();
    check("standby", ana.track, 1'b0);
    c.standby = 1'b0;
    c.start_source_select = `SRC_EXT_PIN;
    c.low_power_track_sel = 1'b1;
    apply();
    check("pin_track", ana.track, 1'b1);
    conv(3, len[0]);
    check("pin_done", done, 1'b1);
    c = '0;
    c.burst_enable_bit = 1'b1;
    c.sar_clock_div = 5'h03;
    c.repeat_count = 3'h1;
    c.power_up_time_field = 5'h02;
    clr();
    conv(0, len[0]);
    check("burst_done", done, 1'b1);
    check("burst_sum", {rhi, rlo}, 16'h0A94);
    check("burst_off", ana.power, 1'b0);
    c.converter_enable_bit = 1'b1;
    conv(0, len[1]);
    check("burst_on", ana.power, 1'b1);
    check("pwrup_len", len[0] - len[1], 24);
    c.converter_enable_bit = 1'b0;
    c.repeat_count = 3'h0;
    c.burst_track_time_field = 6'h01;
    conv(0, len[2]);
    c.burst_track_time_field = 6'h03;
    conv(0, len[3]);
    check("track_len", len[3] - len[2], 16);
    c.twelve_bit_mode_bit = 1'b1;
    c.repeat_count = 3'h1;
    v = 10'h3FF;
    conv(0, len[0]);
    check("b12_max", {rhi, rlo}, 16'h0FFC);
    check("b12_refs", refs, 4'hF);
    check("b12_rots", rots, 4'hF);
    c.repeat_count = 3'h3;
    conv(0, len[0]);
    check("b12_r16", {rhi, rlo}, 16'h3FF0);
    c.twelve_bit_mode_bit = 1'b0;
    c.repeat_count = 3'h1;
    c.start_source_select = `SRC_EXT_PIN;
    v = 10'h2A5;
    clr();
    repeat (3) conv(3, len[0]);
    check("pin_early", done, 1'b0);
    conv(3, len[0]);
    check("pin_series", done, 1'b1);
    check("pin_sum", {rhi, rlo}, 16'h0A94);
    stop_test();
  end
endmodule // adc_track_burst_ctrl_tb_top
